/* File: tb/regfile_model.sv */
// Register-file partner model feeding the address unit its sources.
// Assumes the bench loads sources; valid updates are written back.
`timescale 1ns/1ps
`default_nettype none
module regfile_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic load_i,
	input wire ea_pkg::ea_src_t load_src_i,
	input wire ea_pkg::ea_res_t res_i,
	input wire logic res_valid_i,
	output ea_pkg::ea_src_t src_o
);
	// ----------------------------------------
	// Source registers and write-back
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			src_o <= '0;
		end else if (load_i) begin
			src_o <= load_src_i;
		end else if (res_valid_i && res_i.reg_update_en) begin
			src_o.sel_reg <= res_i.reg_update;
		end
	end
endmodule
`default_nettype wire

/* File: tb/tb_effective_address_generator.sv */
// Self-checking bench for the effective-address unit.
// Assumes a register-file model supplies sources one cycle ahead.
`timescale 1ns/1ps
`default_nettype none
module tb_effective_address_generator;
	localparam logic [31:0] IX = 32'h0000_0104;
	localparam logic [31:0] GB = 32'hffff_ff00;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic en_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic load = 1'b0;
	ea_pkg::ea_req_t req_i = '0;
	ea_pkg::ea_src_t load_src = '0;
	ea_pkg::ea_src_t src_i;
	ea_pkg::ea_res_t res_o;
	logic res_valid_o;
	int n_errors = 0;
	int checks = 0;

	always #2.5 clk_i = ~clk_i;

	effective_address_generator i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(en_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .src_i(src_i), .res_o(res_o),
		.res_valid_o(res_valid_o));
	regfile_model i_regs (.clk_i(clk_i), .rst_b_i(rst_b_i), .load_i(load),
		.load_src_i(load_src), .res_i(res_o), .res_valid_i(res_valid_o), .src_o(src_i));

	// ----------------------------------------
	// Compare and transfer tasks
	// ----------------------------------------
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic op(input ea_pkg::ea_mode_t m, input ea_pkg::op_size_t sz,
			input logic [11:0] d, input ea_pkg::lit_kind_t lk, input logic [7:0] lit,
			input logic [31:0] r, input logic [31:0] pc);
		@(posedge clk_i);
		load <= 1'b1;
		load_src <= '{r, IX, GB, pc};
		@(posedge clk_i);
		load <= 1'b0;
		req_valid_i <= 1'b1;
		req_i <= '{m, sz, d, lk, lit};
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		#1;
		chk_flag(res_valid_o, 1'b1, "valid");
	endtask

	task automatic tally_and_finish();
		if (n_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reg_modes();
		op(ea_pkg::MODE_REG_DIRECT, ea_pkg::SIZE_LONG, '0, ea_pkg::LIT_ZERO, '0, 32'h1234_5679, '0);
		chk_word(res_o.operand, 32'h1234_5679, "direct operand");
		chk_flag(res_o.addr_valid, 1'b0, "direct no addr");
		op(ea_pkg::MODE_REG_INDIRECT, ea_pkg::SIZE_BYTE, '0, ea_pkg::LIT_ZERO, '0, 32'h1234_5679, '0);
		chk_word(res_o.addr, 32'h1234_5679, "indirect");
		op(ea_pkg::MODE_REG_INDEXED, ea_pkg::SIZE_LONG, '0, ea_pkg::LIT_ZERO, '0, 32'h0000_0100, '0);
		chk_word(res_o.addr, 32'h0000_0100 + IX, "indexed");
		op(ea_pkg::MODE_GBP_INDEXED, ea_pkg::SIZE_LONG, '0, ea_pkg::LIT_ZERO, '0, '0, '0);
		chk_word(res_o.addr, 32'h0000_0004, "gbp indexed wrap");
	endtask

	task automatic t_step();
		logic [31:0] st;
		for (int s = 0; s < 3; s++) begin
			st = 32'h0000_0001 << s;
			op(ea_pkg::MODE_POST_INC, ea_pkg::op_size_t'(s), '0, ea_pkg::LIT_ZERO, '0, 32'hffff_fffc, '0);
			chk_word(res_o.addr, 32'hffff_fffc, "postinc addr");
			chk_word(res_o.reg_update, 32'hffff_fffc + st, "postinc upd");
			chk_flag(res_o.reg_update_en, 1'b1, "postinc en");
			op(ea_pkg::MODE_PRE_DEC, ea_pkg::op_size_t'(s), '0, ea_pkg::LIT_ZERO, '0, '0, '0);
			chk_word(res_o.addr, 32'h0 - st, "predec addr");
			chk_word(res_o.reg_update, 32'h0 - st, "predec upd");
		end
	endtask

	task automatic t_disp();
		for (int s = 0; s < 3; s++) begin
			op(ea_pkg::MODE_REG_DISP, ea_pkg::op_size_t'(s), 12'hfff, ea_pkg::LIT_ZERO, '0, 32'h0000_1000, '0);
			chk_word(res_o.addr, 32'h0000_1000 + (32'h0000_000f << s), "reg disp");
			op(ea_pkg::MODE_GBP_DISP, ea_pkg::op_size_t'(s), 12'hfff, ea_pkg::LIT_ZERO, '0, '0, '0);
			chk_word(res_o.addr, GB + (32'h0000_00ff << s), "gbp disp");
		end
	endtask

	task automatic t_pc();
		op(ea_pkg::MODE_PC_DISP, ea_pkg::SIZE_WORD, 12'h0ff, ea_pkg::LIT_ZERO, '0, '0, 32'h8000_0006);
		chk_word(res_o.addr, 32'h8000_0204, "pc word");
		op(ea_pkg::MODE_PC_DISP, ea_pkg::SIZE_LONG, 12'h0ff, ea_pkg::LIT_ZERO, '0, '0, 32'h8000_0006);
		chk_word(res_o.addr, 32'h8000_0400, "pc long");
		op(ea_pkg::MODE_BRANCH_SHORT, ea_pkg::SIZE_WORD, 12'hf80, ea_pkg::LIT_ZERO, '0, '0, 32'h8000_0006);
		chk_word(res_o.addr, 32'h7fff_ff06, "short branch");
		op(ea_pkg::MODE_BRANCH_LONG, ea_pkg::SIZE_WORD, 12'h800, ea_pkg::LIT_ZERO, '0, '0, 32'h8000_0006);
		chk_word(res_o.addr, 32'h7fff_f006, "long branch");
		op(ea_pkg::MODE_BRANCH_REG, ea_pkg::SIZE_WORD, '0, ea_pkg::LIT_ZERO, '0, 32'h0000_0101, 32'h8000_0006);
		chk_word(res_o.addr, 32'h8000_0107, "reg branch");
	endtask

	task automatic t_lit();
		op(ea_pkg::MODE_REG_DIRECT, ea_pkg::SIZE_BYTE, '0, ea_pkg::LIT_ZERO, 8'h9c, '0, '0);
		chk_word(res_o.imm, 32'h0000_009c, "lit zero");
		op(ea_pkg::MODE_REG_DIRECT, ea_pkg::SIZE_BYTE, '0, ea_pkg::LIT_SIGN, 8'h9c, '0, '0);
		chk_word(res_o.imm, 32'hffff_ff9c, "lit sign");
		op(ea_pkg::MODE_REG_DIRECT, ea_pkg::SIZE_BYTE, '0, ea_pkg::LIT_TRAP, 8'h9c, '0, '0);
		chk_word(res_o.imm, 32'h0000_0270, "lit trap");
	endtask

	task automatic t_freeze();
		op(ea_pkg::MODE_REG_INDIRECT, ea_pkg::SIZE_BYTE, '0, ea_pkg::LIT_ZERO, '0, 32'h0000_0055, '0);
		@(posedge clk_i);
		en_i <= 1'b0;
		req_valid_i <= 1'b1;
		req_i <= '{ea_pkg::MODE_REG_DIRECT, ea_pkg::SIZE_BYTE, 12'h000, ea_pkg::LIT_ZERO, 8'h00};
		#1;
		chk_flag(res_valid_o, 1'b0, "valid drop");
		repeat (2) @(posedge clk_i);
		#1;
		chk_flag(res_valid_o, 1'b0, "frozen valid");
		chk_word(res_o.addr, 32'h0000_0055, "frozen addr");
		chk_flag(res_o.operand_valid, 1'b0, "frozen operand");
		@(posedge clk_i);
		en_i <= 1'b1;
		req_valid_i <= 1'b0;
	endtask

	task automatic t_align();
		logic e;
		for (int s = 0; s < 3; s++) begin
			for (int r = 0; r < 4; r++) begin
				e = (s == 1 && r[0]) || (s == 2 && r[1:0] != 2'h0);
				op(ea_pkg::MODE_REG_INDIRECT, ea_pkg::op_size_t'(s), '0, ea_pkg::LIT_ZERO, '0, 32'(r), '0);
				chk_flag(res_o.addr_error, e, "align");
			end
		end
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_reg_modes();
		t_step();
		t_disp();
		t_pc();
		t_lit();
		t_freeze();
		t_align();
		tally_and_finish();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: verilog/align_check.sv */
// Flags a misaligned word or longword operand address.
// Assumes size codes from the shared package.
`timescale 1ns/1ps
`default_nettype none
module align_check (
	input wire logic [31:0] addr_i,
	input wire ea_pkg::op_size_t size_i,
	output logic misaligned_o
);
	always_comb begin
		unique case (size_i)
			ea_pkg::SIZE_WORD: misaligned_o = addr_i[0];
			ea_pkg::SIZE_LONG: misaligned_o = |addr_i[1:0];
			default: misaligned_o = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* File: verilog/disp_scaler.sv */
// Zero-extends and scales a displacement by operand size.
// Assumes size codes from the shared package.
`timescale 1ns/1ps
`default_nettype none
module disp_scaler #(
	parameter int unsigned IN_W = 8
) (
	input wire logic [IN_W-1:0] disp_i,
	input wire ea_pkg::op_size_t size_i,
	output logic [31:0] scaled_o
);
	logic [31:0] ext;

	always_comb begin
		ext = {{(32-IN_W){1'b0}}, disp_i};
		unique case (size_i)
			ea_pkg::SIZE_WORD: scaled_o = ext << ea_pkg::SHIFT_WORD;
			ea_pkg::SIZE_LONG: scaled_o = ext << ea_pkg::SHIFT_LONG;
			default: scaled_o = ext;
		endcase
	end
endmodule
`default_nettype wire

/* File: verilog/ea_pkg.sv */
// Shared types and constants for the effective-address unit.
// Assumes a 32-bit core with decoded mode and size from the decoder.
package ea_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned DISP4_W = 4;
	localparam int unsigned DISP8_W = 8;
	localparam int unsigned DISP12_W = 12;
	localparam int unsigned LIT_W = 8;
	localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
	localparam logic [31:0] STEP_WORD = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG = 32'h0000_0004;
	localparam logic [31:0] LONG_PC_MASK = 32'hffff_fffc;
	localparam int unsigned SHIFT_WORD = 1;
	localparam int unsigned SHIFT_LONG = 2;
	localparam int unsigned TRAP_SHIFT = 2;
	localparam int unsigned BRANCH_SHIFT = 1;

	typedef enum logic [3:0] {
		MODE_REG_DIRECT = 4'h0,
		MODE_REG_INDIRECT = 4'h1,
		MODE_POST_INC = 4'h2,
		MODE_PRE_DEC = 4'h3,
		MODE_REG_DISP = 4'h4,
		MODE_REG_INDEXED = 4'h5,
		MODE_GBP_DISP = 4'h6,
		MODE_GBP_INDEXED = 4'h7,
		MODE_PC_DISP = 4'h8,
		MODE_BRANCH_SHORT = 4'h9,
		MODE_BRANCH_LONG = 4'ha,
		MODE_BRANCH_REG = 4'hb
	} ea_mode_t;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_LONG = 2'h2
	} op_size_t;

	typedef enum logic [1:0] {
		LIT_ZERO = 2'h0,
		LIT_SIGN = 2'h1,
		LIT_TRAP = 2'h2
	} lit_kind_t;

	typedef struct packed {
		ea_mode_t mode;
		op_size_t size;
		logic [11:0] disp;
		lit_kind_t lit_kind;
		logic [7:0] literal;
	} ea_req_t;

	typedef struct packed {
		logic [31:0] sel_reg;
		logic [31:0] index_reg;
		logic [31:0] global_base_pointer;
		logic [31:0] pc;
	} ea_src_t;

	typedef struct packed {
		logic [31:0] addr;
		logic addr_valid;
		logic [31:0] operand;
		logic operand_valid;
		logic [31:0] reg_update;
		logic reg_update_en;
		logic [31:0] imm;
		logic addr_error;
	} ea_res_t;
endpackage

/* File: verilog/effective_address_generator.sv */
// Effective-address, register-update and immediate-extension unit.
// Assumes decoder and register file present request and sources each cycle.
// Overview of operation
// [RULE1] Register-direct: operand is the selected register, no address formed.
// [RULE2] Register-indirect: address is selected register contents unchanged.
// [RULE3] Post-increment: address is register; register then gains 1, 2 or 4.
// [RULE4] Pre-decrement: register loses 1, 2 or 4; that value is address and update.
// [RULE5] Register displacement: 4-bit offset zero-extended, scaled by size, plus register.
// [RULE6] Indexed: address is selected register plus index register zero.
// [RULE7] Global-base displacement: 8-bit offset zero-extended, scaled, plus base pointer.
// [RULE8] Indexed global-base: address is base pointer plus index register zero.
// [RULE9] PC-relative load: 8-bit offset zero-extended, scaled by 2 or 4, plus PC.
// [RULE10] Longword PC-relative load clears the two low PC bits first.
// [RULE11] Short branch: 8-bit offset sign-extended, doubled, plus PC.
// [RULE12] Long branch: 12-bit offset sign-extended, doubled, plus PC.
// [RULE13] Register branch: PC plus full selected register.
// [RULE14] Literal for test, AND, OR, XOR is zero-extended to 32 bits.
// [RULE15] Literal for copy, ADD, equality compare is sign-extended to 32 bits.
// [RULE16] Trap-call literal is zero-extended and multiplied by four.
// [RULE17] Misaligned word or longword operand address raises address error.
// [RULE18] All sums are 32-bit, carries and borrows out of bit 31 dropped.
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	input wire logic req_valid_i,
	input wire ea_pkg::ea_req_t req_i,
	input wire ea_pkg::ea_src_t src_i,
	output ea_pkg::ea_res_t res_o,
	output logic res_valid_o
);
	//----------------------------------------
	// Combinational address datapath
	//----------------------------------------
	logic [31:0] scaled4;
	logic [31:0] scaled8;
	logic [31:0] step;
	logic [31:0] pc_base;
	logic [31:0] pc_scaled;
	logic misaligned;
	ea_pkg::ea_res_t res_nxt;
	ea_pkg::ea_res_t res_r;
	logic valid_nxt;
	logic valid_r;

	disp_scaler #(.IN_W(ea_pkg::DISP4_W)) u_scale4 (
		.disp_i(req_i.disp[3:0]),
		.size_i(req_i.size),
		.scaled_o(scaled4)
	);

	disp_scaler #(.IN_W(ea_pkg::DISP8_W)) u_scale8 (
		.disp_i(req_i.disp[7:0]),
		.size_i(req_i.size),
		.scaled_o(scaled8)
	);

	align_check u_align (
		.addr_i(res_nxt.addr),
		.size_i(req_i.size),
		.misaligned_o(misaligned)
	);

	always_comb begin
		unique case (req_i.size)
			ea_pkg::SIZE_WORD: step = ea_pkg::STEP_WORD; // RULE3
			ea_pkg::SIZE_LONG: step = ea_pkg::STEP_LONG; // RULE3
			default: step = ea_pkg::STEP_BYTE; // RULE3
		endcase
		if (req_i.size == ea_pkg::SIZE_LONG) begin
			pc_base = src_i.pc & ea_pkg::LONG_PC_MASK; // RULE10
			pc_scaled = {24'h000000, req_i.disp[7:0]} << ea_pkg::SHIFT_LONG; // RULE9
		end else begin
			pc_base = src_i.pc;
			pc_scaled = {24'h000000, req_i.disp[7:0]} << ea_pkg::SHIFT_WORD; // RULE9
		end
	end

	always_comb begin
		res_nxt = '0;
		unique case (req_i.mode)
			ea_pkg::MODE_REG_DIRECT: begin
				res_nxt.operand = src_i.sel_reg; // RULE1
				res_nxt.operand_valid = 1'b1; // RULE1
			end
			ea_pkg::MODE_REG_INDIRECT: begin
				res_nxt.addr = src_i.sel_reg; // RULE2
				res_nxt.addr_valid = 1'b1;
			end
			ea_pkg::MODE_POST_INC: begin
				res_nxt.addr = src_i.sel_reg; // RULE3
				res_nxt.addr_valid = 1'b1;
				res_nxt.reg_update = src_i.sel_reg + step; // RULE3 RULE18
				res_nxt.reg_update_en = 1'b1;
			end
			ea_pkg::MODE_PRE_DEC: begin
				res_nxt.addr = src_i.sel_reg - step; // RULE4 RULE18
				res_nxt.addr_valid = 1'b1;
				res_nxt.reg_update = src_i.sel_reg - step; // RULE4
				res_nxt.reg_update_en = 1'b1;
			end
			ea_pkg::MODE_REG_DISP: begin
				res_nxt.addr = src_i.sel_reg + scaled4; // RULE5
				res_nxt.addr_valid = 1'b1;
			end
			ea_pkg::MODE_REG_INDEXED: begin
				res_nxt.addr = src_i.sel_reg + src_i.index_reg; // RULE6
				res_nxt.addr_valid = 1'b1;
			end
			ea_pkg::MODE_GBP_DISP: begin
				res_nxt.addr = src_i.global_base_pointer + scaled8; // RULE7
				res_nxt.addr_valid = 1'b1;
			end
			ea_pkg::MODE_GBP_INDEXED: begin
				res_nxt.addr = src_i.global_base_pointer + src_i.index_reg; // RULE8
				res_nxt.addr_valid = 1'b1;
			end
			ea_pkg::MODE_PC_DISP: begin
				res_nxt.addr = pc_base + pc_scaled; // RULE9 RULE10
				res_nxt.addr_valid = 1'b1;
			end
			ea_pkg::MODE_BRANCH_SHORT: begin
				res_nxt.addr = src_i.pc + {{23{req_i.disp[7]}}, req_i.disp[7:0], 1'b0}; // RULE11
				res_nxt.addr_valid = 1'b1;
			end
			ea_pkg::MODE_BRANCH_LONG: begin
				res_nxt.addr = src_i.pc + {{19{req_i.disp[11]}}, req_i.disp, 1'b0}; // RULE12
				res_nxt.addr_valid = 1'b1;
			end
			ea_pkg::MODE_BRANCH_REG: begin
				res_nxt.addr = src_i.pc + src_i.sel_reg; // RULE13
				res_nxt.addr_valid = 1'b1;
			end
			default: begin
				res_nxt.addr_valid = 1'b0;
			end
		endcase
		unique case (req_i.lit_kind)
			ea_pkg::LIT_SIGN: res_nxt.imm = {{24{req_i.literal[7]}}, req_i.literal}; // RULE15
			ea_pkg::LIT_TRAP: res_nxt.imm = {22'h000000, req_i.literal, 2'h0}; // RULE16
			default: res_nxt.imm = {24'h000000, req_i.literal}; // RULE14
		endcase
	end

	//----------------------------------------
	// Output registers
	//----------------------------------------
	logic is_branch;
	ea_pkg::ea_res_t res_nxt_err;
	assign is_branch = (req_i.mode == ea_pkg::MODE_BRANCH_SHORT) ||
		(req_i.mode == ea_pkg::MODE_BRANCH_LONG) || (req_i.mode == ea_pkg::MODE_BRANCH_REG);

	always_comb begin
		valid_nxt = req_valid_i;
		res_nxt_err = res_nxt;
		// Branch targets are not data operands, so no alignment check
		res_nxt_err.addr_error = res_nxt.addr_valid && !is_branch && misaligned; // RULE17
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			res_r <= '0;
			valid_r <= 1'b0;
		end else if (en_i) begin
			res_r <= res_nxt_err;
			valid_r <= valid_nxt;
		end
	end

	assign res_o = res_r;
	assign res_valid_o = valid_r;

	//----------------------------------------
	// Checks
	//----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence take_s;
		en_i && req_valid_i;
	endsequence

	post_inc_step_a: assert property (take_s and req_i.mode == ea_pkg::MODE_POST_INC ##1 1'b1 |->
		res_o.reg_update == res_o.addr + (($past(req_i.size) == ea_pkg::SIZE_LONG) ? 32'h4 :
		($past(req_i.size) == ea_pkg::SIZE_WORD) ? 32'h2 : 32'h1)) // RULE3
		else $error("post increment step wrong");
	pre_dec_addr_a: assert property (take_s and req_i.mode == ea_pkg::MODE_PRE_DEC |=>
		res_o.addr == res_o.reg_update && res_o.reg_update_en) // RULE4
		else $error("pre decrement address differs from update");
	reg_direct_a: assert property (take_s and req_i.mode == ea_pkg::MODE_REG_DIRECT |=>
		res_o.operand_valid && !res_o.addr_valid && res_o.operand == $past(src_i.sel_reg)) // RULE1
		else $error("register direct operand wrong");
	reg_indirect_a: assert property (take_s and req_i.mode == ea_pkg::MODE_REG_INDIRECT |=>
		res_o.addr == $past(src_i.sel_reg) && !res_o.reg_update_en) // RULE2
		else $error("register indirect address wrong");
	indexed_sum_a: assert property (take_s and req_i.mode == ea_pkg::MODE_REG_INDEXED |=>
		res_o.addr == $past(src_i.sel_reg) + $past(src_i.index_reg)) // RULE6
		else $error("indexed address wrong");
	gbp_indexed_a: assert property (take_s and req_i.mode == ea_pkg::MODE_GBP_INDEXED |=>
		res_o.addr == $past(src_i.global_base_pointer) + $past(src_i.index_reg)) // RULE8
		else $error("indexed base address wrong");
	pc_long_mask_a: assert property (take_s and req_i.mode == ea_pkg::MODE_PC_DISP and
		req_i.size == ea_pkg::SIZE_LONG |=> res_o.addr[1:0] == 2'h0) // RULE10
		else $error("longword pc address not masked");
	branch_reg_a: assert property (take_s and req_i.mode == ea_pkg::MODE_BRANCH_REG |=>
		res_o.addr == $past(src_i.pc) + $past(src_i.sel_reg)) // RULE13
		else $error("register branch target wrong");
	trap_literal_a: assert property (take_s and req_i.lit_kind == ea_pkg::LIT_TRAP |=>
		res_o.imm == {22'h0, $past(req_i.literal), 2'h0}) // RULE16
		else $error("trap offset wrong");
	sign_literal_a: assert property (take_s and req_i.lit_kind == ea_pkg::LIT_SIGN |=>
		res_o.imm[31:8] == {24{res_o.imm[7]}}) // RULE15
		else $error("literal not sign extended");
	align_error_a: assert property (res_valid_o && res_o.addr_valid && res_o.addr[0] &&
		$past(req_i.size) == ea_pkg::SIZE_WORD && $past(req_i.mode) == ea_pkg::MODE_REG_INDIRECT
		&& $past(en_i) |-> res_o.addr_error) // RULE17
		else $error("odd word address not flagged");
endmodule
`default_nettype wire
